// ===== src/rtc_cmp_eval.sv
// Compare window evaluation on the 8 us time view
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_cmp_eval (
  input wire logic [31:0] now, // Current fine time view
  input wire logic [31:0] target, // Programmed compare value
  output logic hit // Compare condition met
);
  localparam logic [31:0] PAST_TICKS = 32'(`RTC_PAST_TICKS);
  localparam logic [31:0] NEAR_TICKS = 32'(`RTC_NEAR_TICKS);
  logic [31:0] ahead;
  logic [31:0] behind;

  // Modular differences so the window works across view wrap
  assign ahead = target - now;
  assign behind = now - target;
  assign hit = (behind <= PAST_TICKS)
             | (ahead <= NEAR_TICKS);
endmodule // rtc_cmp_eval
`default_nettype wire

// ===== src/rtc_defs.svh
// Register offsets, field positions, reset values and time constants
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

`define RTC_AW 8
`define RTC_OFS_IDENT 8'h00
`define RTC_OFS_COUNTER 8'h04
`define RTC_OFS_CHAN_SET 8'h08
`define RTC_OFS_CHAN_CLR 8'h0c
`define RTC_OFS_TFINE 8'h18
`define RTC_OFS_TCOARSE 8'h1c
`define RTC_OFS_CMPVAL 8'h28
`define RTC_OFS_CAPVAL 8'h38
`define RTC_OFS_CAPCFG 8'h3c
`define RTC_OFS_MASK 8'h44
`define RTC_OFS_RAW 8'h48
`define RTC_OFS_MASKED 8'h4c
`define RTC_OFS_FORCE 8'h50
`define RTC_OFS_CLEAR 8'h54
`define RTC_OFS_MASK_SET 8'h58
`define RTC_OFS_MASK_CLR 8'h5c
`define RTC_OFS_DBG 8'h60

`define RTC_BIT_CMP 0
`define RTC_BIT_CAP 1
`define RTC_BIT_EDGE 0
`define RTC_BIT_CNT_CLR 0
`define RTC_BIT_HALT 0

`define RTC_IDENT_DEFAULT 32'h0000_0a5c
`define RTC_RESET_WORD 32'h0000_0000
`define RTC_CNT_W 67
`define RTC_FRAC_W 16
`define RTC_FINE_LSB 3
`define RTC_COARSE_LSB 19
// Low-frequency period in microseconds, with 16 fractional bits
`define RTC_TICK_INC_DEFAULT 32'h001e_8480

`define RTC_VIEW_LSB_US 8
`define RTC_PAST_WINDOW_US 1000000
`define RTC_NEAR_WINDOW_US 32
`define RTC_PAST_TICKS (`RTC_PAST_WINDOW_US / `RTC_VIEW_LSB_US)
`define RTC_NEAR_TICKS (`RTC_NEAR_WINDOW_US / `RTC_VIEW_LSB_US)

`define RTC_RESP_OKAY 2'b00
`define RTC_RESP_SLVERR 2'b10

`endif

// ===== src/rtc_pkg.sv
// Types shared by the real-time clock design
`include "rtc_defs.svh"
package rtc_pkg;

  typedef struct packed {
    logic awvalid;
    logic [`RTC_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`RTC_AW-1:0] araddr;
    logic rready;
  } rtc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rtc_axi_rsp_t;

  typedef struct packed {
    logic [`RTC_CNT_W-1:0] count;
    logic [`RTC_FRAC_W-1:0] frac;
  } rtc_cnt_state_t;

  typedef struct packed {
    logic aw_held;
    logic [`RTC_AW-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] cmp_val;
    logic [31:0] cap_val;
    logic edge_fall;
    logic cap_prev;
    logic [1:0] armed;
    logic [1:0] raw;
    logic [1:0] mask;
    logic clr_pend;
    logic dbg_halt;
  } rtc_state_t;

endpackage

// ===== src/rtc_time_counter.sv
// Free-running 67-bit time counter with fraction, advanced per low-freq tick
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_time_counter #(
  parameter logic [31:0] TICK_INC = `RTC_TICK_INC_DEFAULT
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic chip_off, // Chip in reset or shutdown
  input wire logic low_freq_clock, // One-cycle tick per low-freq edge
  input wire logic clr_req, // Counter clear pending
  output logic clr_done, // Pulse: clear applied on this tick
  output logic [31:0] time_fine_view, // Counter bits 34:3
  output logic [31:0] time_coarse_view // Counter bits 50:19
);
  import rtc_pkg::*;

  localparam int SUM_W = `RTC_CNT_W + `RTC_FRAC_W;
  rtc_cnt_state_t s;
  rtc_cnt_state_t next_s;
  logic [SUM_W-1:0] sum;

  always_comb begin
    next_s = s;
    sum = {s.count, s.frac} + {{(SUM_W-32){1'b0}}, TICK_INC};
    clr_done = low_freq_clock & clr_req;
    if (clr_done) begin
      next_s = '0;
    end else if (low_freq_clock) begin
      next_s = sum;
    end
    if (chip_off) begin
      next_s = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign time_fine_view = s.count[`RTC_FINE_LSB +: 32];
  assign time_coarse_view = s.count[`RTC_COARSE_LSB +: 32];
endmodule // rtc_time_counter
`default_nettype wire

// ===== src/rtc_top.sv
// Real-time clock with compare and capture channels on AXI4-Lite
//
// Overview of operation
// - A 67-bit time counter advances on low-freq ticks in active and standby.
// - Chip reset or shutdown clears the counter and all channel state.
// - Each low-freq tick adds the period in microseconds with 16 fraction bits.
// - The fine view returns counter bits 34:3, one LSB per 8 us.
// - The coarse view returns counter bits 50:19, about half a second per LSB.
// - Capture edge bit: 0 selects rising edge, 1 selects falling edge.
// - While armed, each selected capture edge loads the fine view into capture value.
// - Reading the capture value clears the capture raw status.
// - Writing the compare value clears the compare raw status.
// - Writing the compare value arms compare; its event disarms it.
// - A compare value up to one second in the past fires at once.
// - Otherwise compare fires once the target is within 32 us ahead.
// - The arm-set and arm-clear reads show one armed bit per channel.
// - The arm-set bit 1 arms capture; bit 0 and zeros do nothing.
// - An arm-clear write disarms without event; a same-cycle event fires.
// - Both channel interrupts share one interrupt request output.
// - Masked status is raw status AND mask; a set mask bit unmasks.
// - Force-set writes of 1 set raw status bits.
// - Clear writes of 1 clear raw status and so masked status.
// - Mask-set ones set mask bits, mask-clear ones clear them.
// - Channel events, notably compare, drive a standby wake request.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_top #(
  parameter logic [31:0] IDENT = `RTC_IDENT_DEFAULT, // Arbitrary value
  parameter logic [31:0] TICK_INC = `RTC_TICK_INC_DEFAULT
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic chip_off, // Chip in reset or shutdown state
  input wire logic low_freq_clock, // One-cycle tick per low-freq edge
  input wire logic capture_event, // Event fabric capture input
  input wire rtc_pkg::rtc_axi_req_t axi_req, // AXI4-Lite requests
  output var rtc_pkg::rtc_axi_rsp_t axi_rsp, // AXI4-Lite answers
  output logic irq, // Combined interrupt request
  output logic wake_request // Standby wake request
);
  import rtc_pkg::*;

  rtc_state_t s;
  rtc_state_t next_s;
  logic [31:0] fine;
  logic [31:0] coarse;
  logic clr_done;
  logic cmp_hit;
  logic cmp_fire;
  logic cap_edge;
  logic cap_fire;
  logic do_wr;
  logic do_rd;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [1:0] wch;
  logic [1:0] status_clr;
  logic [1:0] status_set;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;
  logic [`RTC_AW-1:0] wr_ofs;
  logic [`RTC_AW-1:0] rd_ofs;

  rtc_time_counter #(
    .TICK_INC(TICK_INC)
  ) u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .chip_off(chip_off),
    .low_freq_clock(low_freq_clock),
    .clr_req(s.clr_pend),
    .clr_done(clr_done),
    .time_fine_view(fine),
    .time_coarse_view(coarse)
  );

  rtc_cmp_eval u_cmp (
    .now(fine),
    .target(s.cmp_val),
    .hit(cmp_hit)
  );

  // Word-aligned offsets; byte lanes are ignored in decode
  assign wr_ofs = {s.aw_addr[`RTC_AW-1:2], 2'b00};
  assign rd_ofs = {axi_req.araddr[`RTC_AW-1:2], 2'b00};

  always_comb begin
    wmask = '0;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{s.w_strb[i]}};
    end
  end

  assign wbits = s.w_data & wmask;
  assign wch = wbits[1:0];

  // Read decode; unmapped offsets answer with an error and zero data
  always_comb begin
    rd_word = `RTC_RESET_WORD;
    rd_ok = 1'b1;
    unique case (rd_ofs)
      `RTC_OFS_IDENT: rd_word = IDENT;
      `RTC_OFS_COUNTER: rd_word[`RTC_BIT_CNT_CLR] = s.clr_pend;
      `RTC_OFS_CHAN_SET: rd_word[1:0] = s.armed;
      `RTC_OFS_CHAN_CLR: rd_word[1:0] = s.armed;
      `RTC_OFS_TFINE: rd_word = fine;
      `RTC_OFS_TCOARSE: rd_word = coarse;
      `RTC_OFS_CMPVAL: rd_word = s.cmp_val;
      `RTC_OFS_CAPVAL: rd_word = s.cap_val;
      `RTC_OFS_CAPCFG: rd_word[`RTC_BIT_EDGE] = s.edge_fall;
      `RTC_OFS_MASK: rd_word[1:0] = s.mask;
      `RTC_OFS_RAW: rd_word[1:0] = s.raw;
      `RTC_OFS_MASKED: rd_word[1:0] = s.raw & s.mask;
      `RTC_OFS_FORCE,
      `RTC_OFS_CLEAR,
      `RTC_OFS_MASK_SET,
      `RTC_OFS_MASK_CLR: rd_word = `RTC_RESET_WORD;
      `RTC_OFS_DBG: rd_word[`RTC_BIT_HALT] = s.dbg_halt;
      default: rd_ok = 1'b0;
    endcase
  end

  // Write decode validity only
  always_comb begin
    unique case (wr_ofs)
      `RTC_OFS_IDENT,
      `RTC_OFS_COUNTER,
      `RTC_OFS_CHAN_SET,
      `RTC_OFS_CHAN_CLR,
      `RTC_OFS_TFINE,
      `RTC_OFS_TCOARSE,
      `RTC_OFS_CMPVAL,
      `RTC_OFS_CAPVAL,
      `RTC_OFS_CAPCFG,
      `RTC_OFS_MASK,
      `RTC_OFS_RAW,
      `RTC_OFS_MASKED,
      `RTC_OFS_FORCE,
      `RTC_OFS_CLEAR,
      `RTC_OFS_MASK_SET,
      `RTC_OFS_MASK_CLR,
      `RTC_OFS_DBG: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  assign do_wr = s.aw_held & s.w_held & ~s.bvalid;
  assign do_rd = axi_req.arvalid & ~s.rvalid;

  // Channel events are judged on the state before this cycle's writes
  assign cmp_fire = s.armed[`RTC_BIT_CMP] & cmp_hit;
  assign cap_edge = s.edge_fall
                  ? (s.cap_prev & ~capture_event)
                  : (~s.cap_prev & capture_event);
  assign cap_fire = s.armed[`RTC_BIT_CAP] & cap_edge;

  always_comb begin
    status_clr = 2'b00;
    status_set = 2'b00;
    if (do_wr && wr_ofs == `RTC_OFS_CLEAR) begin
      status_clr = status_clr | wch;
    end
    if (do_wr && wr_ofs == `RTC_OFS_CMPVAL) begin
      status_clr[`RTC_BIT_CMP] = 1'b1;
    end
    if (do_rd && rd_ofs == `RTC_OFS_CAPVAL) begin
      status_clr[`RTC_BIT_CAP] = 1'b1;
    end
    if (do_wr && wr_ofs == `RTC_OFS_FORCE) begin
      status_set = status_set | wch;
    end
    status_set[`RTC_BIT_CMP] = status_set[`RTC_BIT_CMP] | cmp_fire;
    status_set[`RTC_BIT_CAP] = status_set[`RTC_BIT_CAP] | cap_fire;
  end

  always_comb begin
    next_s = s;
    next_s.cap_prev = capture_event;

    // Bus address and data channels are held independently
    if (axi_req.awvalid && !s.aw_held) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s.w_held) begin
      next_s.w_held = 1'b1;
      next_s.w_data = axi_req.wdata;
      next_s.w_strb = axi_req.wstrb;
    end
    if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (do_wr) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_ok ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
    end
    if (do_rd) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word;
      next_s.rresp = rd_ok ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
    end

    // Event disarm comes first so a later write can re-arm
    if (cmp_fire) begin
      next_s.armed[`RTC_BIT_CMP] = 1'b0;
    end
    if (cap_fire) begin
      next_s.cap_val = fine;
    end
    if (clr_done) begin
      next_s.clr_pend = 1'b0;
    end

    if (do_wr) begin
      unique case (wr_ofs)
        `RTC_OFS_COUNTER: begin
          if (wbits[`RTC_BIT_CNT_CLR]) begin
            next_s.clr_pend = 1'b1;
          end
        end
        `RTC_OFS_CHAN_SET: begin
          if (wch[`RTC_BIT_CAP]) begin
            next_s.armed[`RTC_BIT_CAP] = 1'b1;
          end
        end
        `RTC_OFS_CHAN_CLR: begin
          // Event already latched above, so disarming cannot hide it
          next_s.armed = next_s.armed & ~wch;
        end
        `RTC_OFS_CMPVAL: begin
          next_s.cmp_val = (s.cmp_val & ~wmask) | wbits;
          next_s.armed[`RTC_BIT_CMP] = 1'b1;
        end
        `RTC_OFS_CAPCFG: begin
          if (s.w_strb[0]) begin
            next_s.edge_fall = s.w_data[`RTC_BIT_EDGE];
          end
        end
        `RTC_OFS_MASK_SET: begin
          next_s.mask = s.mask | wch;
        end
        `RTC_OFS_MASK_CLR: begin
          next_s.mask = s.mask & ~wch;
        end
        `RTC_OFS_DBG: begin
          if (s.w_strb[0]) begin
            next_s.dbg_halt = s.w_data[`RTC_BIT_HALT];
          end
        end
        default: begin
        end
      endcase
    end

    // Hardware set wins over a clear in the same cycle
    next_s.raw = (s.raw & ~status_clr) | status_set;

    if (chip_off) begin
      next_s.cmp_val = '0;
      next_s.cap_val = '0;
      next_s.edge_fall = 1'b0;
      next_s.armed = '0;
      next_s.raw = '0;
      next_s.mask = '0;
      next_s.clr_pend = 1'b0;
      next_s.dbg_halt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    axi_rsp.awready = ~s.aw_held;
    axi_rsp.wready = ~s.w_held;
    axi_rsp.bvalid = s.bvalid;
    axi_rsp.bresp = s.bresp;
    axi_rsp.arready = ~s.rvalid;
    axi_rsp.rvalid = s.rvalid;
    axi_rsp.rdata = s.rdata;
    axi_rsp.rresp = s.rresp;
  end

  assign irq = |(s.raw & s.mask);
  // Wake ignores the mask: standby wake must not rely on software masking
  assign wake_request = |s.raw;
endmodule // rtc_top
`default_nettype wire

// ===== tb/rtc_top_chk.sv
// Concurrent checks on the real-time clock block's ports
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_chk (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic chip_off, // Chip reset or shutdown
  input wire logic low_freq_clock, // Low-freq tick
  input wire logic capture_event, // Capture input
  input wire rtc_pkg::rtc_axi_req_t axi_req, // Bus requests
  input wire rtc_pkg::rtc_axi_rsp_t axi_rsp, // Bus answers
  input wire logic irq, // Combined interrupt
  input wire logic wake_request // Wake request
);
  import rtc_pkg::*;
  logic wr_take;
  // Only a write that can start at once, so its answer is not delayed
  assign wr_take = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid &&
                   axi_rsp.wready && !axi_rsp.bvalid;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  sequence s_force0;
    wr_take && axi_req.awaddr == `RTC_OFS_FORCE && axi_req.wdata[0] &&
    axi_req.wstrb[0] && !chip_off ##1 !chip_off ##1 !chip_off;
  endsequence
  a_read_answer:
    assert property (s_ar_take |=> axi_rsp.rvalid)
    else $error("read not answered one cycle after address");
  a_read_stands:
    assert property (axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read answer dropped or changed before taken");
  a_write_answer:
    assert property (wr_take |-> ##[1:2] axi_rsp.bvalid)
    else $error("write response late");
  a_unmapped_err:
    assert property (s_ar_take and axi_req.araddr == 8'h10 |=>
      axi_rsp.rresp == `RTC_RESP_SLVERR && axi_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  a_irq_raw:
    assert property (irq |-> wake_request)
    else $error("interrupt without raw status");
  a_off_clears:
    assert property (chip_off |=> !irq && !wake_request)
    else $error("shutdown left status set");
  a_raw_sticky:
    assert property ($fell(wake_request) |-> $past(chip_off) ||
      $rose(axi_rsp.bvalid) || $rose(axi_rsp.rvalid))
    else $error("raw status dropped without software");
  a_force_sets:
    assert property (s_force0 |-> wake_request)
    else $error("force-set did not set raw status");
endmodule // rtc_chk

bind rtc_top rtc_chk chk_u (
  .aclk(aclk),
  .aresetn(aresetn),
  .chip_off(chip_off),
  .low_freq_clock(low_freq_clock),
  .capture_event(capture_event),
  .axi_req(axi_req),
  .axi_rsp(axi_rsp),
  .irq(irq),
  .wake_request(wake_request)
);
`default_nettype wire

// ===== tb/tb_rtc_top.sv
// Register-level test bench for the real-time clock block
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module tb_rtc_top;
  import rtc_pkg::*;
  localparam logic [31:0] IDENT = 32'h0000_1234; // Arbitrary value
  // Large increment: fine view +0x800 per tick, coarse +1 per 32 ticks
  localparam logic [31:0] TINC = 32'h4000_0000;
  localparam logic [63:0] STEP = 64'h4000;
  localparam logic [31:0] PAST = 32'd125000;
  localparam logic [31:0] DOFS [4] = '{-PAST, -PAST - 32'd1, 32'd4, 32'd5};
  localparam logic [3:0] DHIT = 4'b0101;
  localparam logic [7:0] ZR [16] = '{`RTC_OFS_COUNTER, `RTC_OFS_CHAN_SET,
    `RTC_OFS_CHAN_CLR, `RTC_OFS_TFINE, `RTC_OFS_TCOARSE, `RTC_OFS_CMPVAL,
    `RTC_OFS_CAPVAL, `RTC_OFS_CAPCFG, `RTC_OFS_MASK, `RTC_OFS_RAW,
    `RTC_OFS_MASKED, `RTC_OFS_FORCE, `RTC_OFS_CLEAR, `RTC_OFS_MASK_SET,
    `RTC_OFS_MASK_CLR, `RTC_OFS_DBG};
  logic aclk, aresetn, chip_off, lfc, cev, irq, wake;
  rtc_axi_req_t req;
  rtc_axi_rsp_t rsp;
  int failures, comparisons, cyc, nt;
  logic [31:0] rdat;
  logic [1:0] rrsp, brsp;
  rtc_top #(.IDENT(IDENT), .TICK_INC(TINC)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .chip_off(chip_off),
    .low_freq_clock(lfc), .capture_event(cev), .axi_req(req),
    .axi_rsp(rsp), .irq(irq), .wake_request(wake));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic stop_test;
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Valids held until their own ready; bready stays high
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    do begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    brsp = rsp.bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    // Late rready makes each answer stand a cycle before it is taken
    do begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      req.rready <= rsp.rvalid && !req.rready;
    end while (rsp.rvalid !== 1'b1 || req.rready !== 1'b1);
    rdat = rsp.rdata;
    rrsp = rsp.rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      lfc <= 1'b1;
      @(posedge aclk);
      lfc <= 1'b0;
      @(posedge aclk);
      nt++;
    end
  endtask
  function automatic logic [31:0] fv(input int sh);
    logic [63:0] c;
    c = STEP * 64'(nt);
    return 32'(c >> sh);
  endfunction
  initial begin
    aresetn = 1'b0;
    chip_off = 1'b0;
    lfc = 1'b0;
    cev = 1'b0;
    req = '0;
    req.wstrb = 4'hf;
    req.bready = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (ZR[i]) rc(ZR[i], 32'h0);
    rc(`RTC_OFS_IDENT, IDENT);
    rd(8'h10);
    chk({30'h0, rrsp}, {30'h0, `RTC_RESP_SLVERR});
    wr(8'h10, 32'hffff_ffff);
    chk({30'h0, brsp}, {30'h0, `RTC_RESP_SLVERR});
    wr(`RTC_OFS_DBG, 32'h1);
    rc(`RTC_OFS_DBG, 32'h1);
    tk(40);
    rc(`RTC_OFS_TFINE, fv(3));
    rc(`RTC_OFS_TCOARSE, fv(19));
    wr(`RTC_OFS_COUNTER, 32'h1);
    rc(`RTC_OFS_COUNTER, 32'h1);
    rc(`RTC_OFS_TFINE, fv(3));
    tk(1);
    nt = 0;
    rc(`RTC_OFS_TFINE, 32'h0);
    tk(3);
    wr(`RTC_OFS_MASK_SET, 32'h1);
    rc(`RTC_OFS_MASK, 32'h1);
    wr(`RTC_OFS_CMPVAL, fv(3) + 32'h800);
    rc(`RTC_OFS_CHAN_SET, 32'h1);
    rc(`RTC_OFS_RAW, 32'h0);
    tk(1);
    rc(`RTC_OFS_RAW, 32'h1);
    chk({30'h0, irq, wake}, 32'h3);
    rc(`RTC_OFS_CHAN_CLR, 32'h0);
    rc(`RTC_OFS_MASKED, 32'h1);
    wr(`RTC_OFS_MASK_CLR, 32'h1);
    rc(`RTC_OFS_MASKED, 32'h0);
    wr(`RTC_OFS_CLEAR, 32'h1);
    rc(`RTC_OFS_RAW, 32'h0);
    wr(`RTC_OFS_FORCE, 32'h1);
    rc(`RTC_OFS_RAW, 32'h1);
    wr(`RTC_OFS_CMPVAL, fv(3) + 32'h800);
    rc(`RTC_OFS_RAW, 32'h0);
    wr(`RTC_OFS_CHAN_CLR, 32'h1);
    tk(1);
    rc(`RTC_OFS_RAW, 32'h0);
    rc(`RTC_OFS_CHAN_SET, 32'h0);
    // Window edges: one second behind, and 32 us ahead
    for (int i = 0; i < 4; i++) begin
      wr(`RTC_OFS_CMPVAL, fv(3) + DOFS[i]);
      rc(`RTC_OFS_RAW, {31'h0, DHIT[i]});
      rc(`RTC_OFS_CHAN_SET, {31'h0, !DHIT[i]});
      wr(`RTC_OFS_CHAN_CLR, 32'h1);
      wr(`RTC_OFS_CLEAR, 32'h1);
    end
    wr(`RTC_OFS_CHAN_SET, 32'h3);
    rc(`RTC_OFS_CHAN_CLR, 32'h2);
    for (int e = 0; e < 2; e++) begin
      wr(`RTC_OFS_CAPCFG, 32'(e));
      cev <= e[0];
      tk(1);
      rc(`RTC_OFS_RAW, 32'h0);
      cev <= !e[0];
      repeat (2) @(posedge aclk);
      rc(`RTC_OFS_RAW, 32'h2);
      rc(`RTC_OFS_CAPVAL, fv(3));
      rc(`RTC_OFS_RAW, 32'h0);
      cev <= e[0];
      repeat (2) @(posedge aclk);
      rc(`RTC_OFS_RAW, 32'h0);
    end
    rc(`RTC_OFS_CHAN_SET, 32'h2);
    wr(`RTC_OFS_CHAN_CLR, 32'h2);
    cev <= 1'b0;
    repeat (2) @(posedge aclk);
    rc(`RTC_OFS_RAW, 32'h0);
    wr(`RTC_OFS_MASK_SET, 32'h3);
    wr(`RTC_OFS_FORCE, 32'h3);
    wr(`RTC_OFS_CHAN_SET, 32'h2);
    chk({30'h0, irq, wake}, 32'h3);
    chip_off <= 1'b1;
    @(posedge aclk);
    chip_off <= 1'b0;
    nt = 0;
    rc(`RTC_OFS_RAW, 32'h0);
    rc(`RTC_OFS_MASK, 32'h0);
    rc(`RTC_OFS_CHAN_SET, 32'h0);
    rc(`RTC_OFS_TFINE, 32'h0);
    stop_test();
  end
endmodule // tb_rtc_top
`default_nettype wire
